// ### rtl/adcr_params.svh
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH
// Register byte addresses
`define ADCR_ADDR_CTRL 8'h00
`define ADCR_ADDR_RESH 8'h04
`define ADCR_ADDR_RESL 8'h08
`define ADCR_ADDR_DATA 8'h0c
// Control register fields
`define ADCR_BIT_JUSTIFY 7
`define ADCR_BIT_REFSEL 6
`define ADCR_SEL_HI 4
`define ADCR_SEL_LO 2
`define ADCR_BIT_GO 1
`define ADCR_BIT_ON 0
`define ADCR_CTRL_RESET 8'h00
`define ADCR_CTRL_WMASK 8'hdf
// Conversion time in ns and in cycles of a 10 ns clock
`define ADCR_CONV_NS 1100
`define ADCR_CLK_NS 10
`define ADCR_CONV_CYC ((`ADCR_CONV_NS + `ADCR_CLK_NS - 1) / `ADCR_CLK_NS)
`define ADCR_RES_BITS 10
`define ADCR_HTRANS_NONSEQ 2'h2
`define ADCR_HSIZE_WORD 3'h2
`endif

// ### rtl/adcr_pkg.sv
package adcr_pkg;
  typedef enum logic [2:0] {
    ADCR_EXT_IN0 = 3'h0,
    ADCR_EXT_IN1 = 3'h1,
    ADCR_EXT_IN2 = 3'h2,
    ADCR_EXT_IN3 = 3'h3,
    ADCR_CMP_VREF = 3'h4,
    ADCR_REF_0V6 = 3'h5,
    ADCR_REF_1V2 = 3'h6,
    ADCR_RESERVED = 3'h7
  } adcr_input_t;
  typedef enum logic [1:0] {
    ADCR_IDLE = 2'h0,
    ADCR_CONVERT = 2'h1,
    ADCR_STORE = 2'h2
  } adcr_state_t;
endpackage

// ### rtl/adcr_control.sv
// How it works
// - Reference select 1 routes the external reference pin to the upper reference, 0 the rail.
// - Input select codes 0-3 pick external inputs, 4 comparator ref, 5 0.6V, 6 1.2V, 7 reserved.
// - Writing 1 to convert-go together with converter-on 1 starts a conversion and the flag reads 1 while it runs.
// - Hardware clears convert-go when the conversion ends.
// - Converter-on 1 enables the converter; 0 disables it and stops its operating current.
// - Left justified, the high byte holds result bits 9..2.
// - Left justified, the low byte holds result bits 1..0 at 7..6 and zeros below.
// - Right justified, the high byte holds result bits 9..8 at 1..0.
// - Right justified, high byte bits 7..2 read zero.
// - Right justified, the low byte holds result bits 7..0.
// - Each result is a 10-bit value of 1024 steps held across the two bytes.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adcr_params.svh"
module adcr_control #(
  parameter int RES_BITS = `ADCR_RES_BITS,
  parameter int CONV_CYC = `ADCR_CONV_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [9:0] sampleData,
  output logic converterEnable,
  output logic externalRefSelect,
  output logic [2:0] inputSelect,
  output logic sampleStrobe
);
  initial begin
    if (RES_BITS != `ADCR_RES_BITS || CONV_CYC < 1 || CONV_CYC > 4096) begin
      $error("adcr_control: unsupported parameters");
    end
  end

  logic [7:0] ctrl_reg;
  logic [9:0] result_reg;
  logic [12:0] count_reg;
  adcr_pkg::adcr_state_t state_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic rdPend_reg;
  logic [7:0] rdAddr_reg;
  logic [9:0] dataSync_reg [3];
  logic startReq;
  logic goWrite;
  logic [7:0] resHigh;
  logic [7:0] resLow;

  // Address phase capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      rdAddr_reg <= 8'h00;
    end else if (hready) begin
      wrPend_reg <= hsel && htrans == `ADCR_HTRANS_NONSEQ && hwrite;
      rdPend_reg <= hsel && htrans == `ADCR_HTRANS_NONSEQ && !hwrite;
      wrAddr_reg <= haddr[7:0];
      rdAddr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign goWrite = wrPend_reg && wrAddr_reg == `ADCR_ADDR_CTRL;
  assign startReq = goWrite && hwdata[`ADCR_BIT_GO] && hwdata[`ADCR_BIT_ON];

  // Control register; go bit owned by the sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= `ADCR_CTRL_RESET;
    end else begin
      if (goWrite) begin
        ctrl_reg <= hwdata[7:0] & `ADCR_CTRL_WMASK;
        ctrl_reg[`ADCR_BIT_GO] <= ctrl_reg[`ADCR_BIT_GO] | startReq;
      end
      if (state_reg == adcr_pkg::ADCR_STORE) begin
        ctrl_reg[`ADCR_BIT_GO] <= 1'b0;
      end
      if (goWrite && !hwdata[`ADCR_BIT_ON]) begin
        ctrl_reg[`ADCR_BIT_GO] <= 1'b0;
      end
    end
  end

  // Analog result arrives asynchronously: three-stage sync, accepted when stages 2 and 3 agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataSync_reg[0] <= 10'h000;
      dataSync_reg[1] <= 10'h000;
      dataSync_reg[2] <= 10'h000;
    end else begin
      dataSync_reg[0] <= sampleData;
      dataSync_reg[1] <= dataSync_reg[0];
      dataSync_reg[2] <= dataSync_reg[1];
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= adcr_pkg::ADCR_IDLE;
      count_reg <= 13'h0000;
    end else begin
      unique case (state_reg)
        adcr_pkg::ADCR_IDLE: begin
          if (startReq && !ctrl_reg[`ADCR_BIT_GO]) begin
            state_reg <= adcr_pkg::ADCR_CONVERT;
            count_reg <= 13'(CONV_CYC);
          end
        end
        adcr_pkg::ADCR_CONVERT: begin
          if (!ctrl_reg[`ADCR_BIT_ON]) begin
            state_reg <= adcr_pkg::ADCR_IDLE;
          end else if (count_reg <= 13'h0001 && dataSync_reg[1] == dataSync_reg[2]) begin
            state_reg <= adcr_pkg::ADCR_STORE;
          end else if (count_reg > 13'h0001) begin
            count_reg <= count_reg - 13'h0001;
          end
        end
        adcr_pkg::ADCR_STORE: begin
          state_reg <= adcr_pkg::ADCR_IDLE;
        end
        default: begin
          state_reg <= adcr_pkg::ADCR_IDLE;
        end
      endcase
    end
  end

  // Result latched as the sequencer enters the store state, one cycle before go clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= 10'h000;
    end else if (state_reg == adcr_pkg::ADCR_CONVERT && ctrl_reg[`ADCR_BIT_ON]
                 && count_reg <= 13'h0001 && dataSync_reg[1] == dataSync_reg[2]) begin
      result_reg <= dataSync_reg[2];
    end
  end

  always_comb begin
    if (ctrl_reg[`ADCR_BIT_JUSTIFY]) begin
      resHigh = {6'h00, result_reg[9:8]};
      resLow = result_reg[7:0];
    end else begin
      resHigh = result_reg[9:2];
      resLow = {result_reg[1:0], 6'h00};
    end
  end

  // Read data, registered in the data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans == `ADCR_HTRANS_NONSEQ && !hwrite) begin
      unique case (haddr[7:0])
        `ADCR_ADDR_CTRL: hrdata <= {24'h000000, ctrl_reg};
        `ADCR_ADDR_RESH: hrdata <= {24'h000000, resHigh};
        `ADCR_ADDR_RESL: hrdata <= {24'h000000, resLow};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Analog side controls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converterEnable <= 1'b0;
      externalRefSelect <= 1'b0;
      inputSelect <= adcr_pkg::ADCR_EXT_IN0;
      sampleStrobe <= 1'b0;
    end else begin
      converterEnable <= ctrl_reg[`ADCR_BIT_ON];
      externalRefSelect <= ctrl_reg[`ADCR_BIT_REFSEL];
      inputSelect <= ctrl_reg[`ADCR_SEL_HI:`ADCR_SEL_LO];
      sampleStrobe <= state_reg == adcr_pkg::ADCR_CONVERT;
    end
  end

  property p_go_clears;
    @(posedge clk) disable iff (!rst_n)
      state_reg == adcr_pkg::ADCR_STORE |=> !ctrl_reg[`ADCR_BIT_GO];
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("go not cleared");
  a_go_start: assert property (@(posedge clk) disable iff (!rst_n)
    startReq && !ctrl_reg[`ADCR_BIT_GO] |=> ctrl_reg[`ADCR_BIT_GO])
    else $error("go not set");
  a_off_nostart: assert property (@(posedge clk) disable iff (!rst_n)
    goWrite && !hwdata[`ADCR_BIT_ON] && state_reg == adcr_pkg::ADCR_IDLE
      |=> state_reg == adcr_pkg::ADCR_IDLE)
    else $error("started while off");
  a_on_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 converterEnable == $past(ctrl_reg[`ADCR_BIT_ON]))
    else $error("enable mismatch");
  a_ref_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 externalRefSelect == $past(ctrl_reg[`ADCR_BIT_REFSEL]))
    else $error("reference mismatch");
  a_left_low: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_reg[`ADCR_BIT_JUSTIFY] |-> resLow[5:0] == 6'h00 && resHigh == result_reg[9:2])
    else $error("left layout");
  a_right_high: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[`ADCR_BIT_JUSTIFY] |-> resHigh[7:2] == 6'h00 && resLow == result_reg[7:0])
    else $error("right layout");
  a_result_first: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == adcr_pkg::ADCR_STORE |-> result_reg == $past(dataSync_reg[2]))
    else $error("stale result");

  // Conversion steps, named so the flow checks read as the sequencer does
  sequence s_start_taken;
    state_reg == adcr_pkg::ADCR_IDLE && startReq && !ctrl_reg[`ADCR_BIT_GO];
  endsequence
  sequence s_running;
    state_reg == adcr_pkg::ADCR_CONVERT && ctrl_reg[`ADCR_BIT_GO];
  endsequence
  sequence s_count_loaded;
    count_reg == 13'(CONV_CYC);
  endsequence
  sequence s_last_step;
    state_reg == adcr_pkg::ADCR_CONVERT && ctrl_reg[`ADCR_BIT_ON] && count_reg <= 13'h0001
      && dataSync_reg[1] == dataSync_reg[2];
  endsequence
  sequence s_store_then_done;
    state_reg == adcr_pkg::ADCR_STORE
      ##1 state_reg == adcr_pkg::ADCR_IDLE && !ctrl_reg[`ADCR_BIT_GO];
  endsequence

  // Flow checks
  property p_start_flow;
    @(posedge clk) disable iff (!rst_n)
      s_start_taken |=> s_running;
  endproperty
  a_start_flow: assert property (p_start_flow) else $error("start not taken");
  property p_count_load;
    @(posedge clk) disable iff (!rst_n)
      s_start_taken |=> s_count_loaded;
  endproperty
  a_count_load: assert property (p_count_load) else $error("count not loaded");
  property p_store_step;
    @(posedge clk) disable iff (!rst_n)
      s_last_step |=> s_store_then_done;
  endproperty
  a_store_step: assert property (p_store_step) else $error("end not reached");
  property p_latch_step;
    @(posedge clk) disable iff (!rst_n)
      s_last_step |=> result_reg == $past(dataSync_reg[2]);
  endproperty
  a_latch_step: assert property (p_latch_step) else $error("result not latched");
  property p_busy_go;
    @(posedge clk) disable iff (!rst_n)
      state_reg == adcr_pkg::ADCR_CONVERT && ctrl_reg[`ADCR_BIT_ON] |-> ctrl_reg[`ADCR_BIT_GO];
  endproperty
  a_busy_go: assert property (p_busy_go) else $error("go low while busy");
  property p_go_fall;
    @(posedge clk) disable iff (!rst_n)
      $fell(ctrl_reg[`ADCR_BIT_GO]) |-> $past(state_reg == adcr_pkg::ADCR_STORE)
        || $past(goWrite && !hwdata[`ADCR_BIT_ON]);
  endproperty
  a_go_fall: assert property (p_go_fall) else $error("go fell early");
  property p_idle_nogo;
    @(posedge clk) disable iff (!rst_n)
      state_reg == adcr_pkg::ADCR_IDLE |-> !ctrl_reg[`ADCR_BIT_GO];
  endproperty
  a_idle_nogo: assert property (p_idle_nogo) else $error("go high while idle");
  property p_off_stop;
    @(posedge clk) disable iff (!rst_n)
      state_reg == adcr_pkg::ADCR_CONVERT && !ctrl_reg[`ADCR_BIT_ON] |=> state_reg == adcr_pkg::ADCR_IDLE;
  endproperty
  a_off_stop: assert property (p_off_stop) else $error("ran while off");
  property p_abort_clear;
    @(posedge clk) disable iff (!rst_n)
      goWrite && !hwdata[`ADCR_BIT_ON] |=> !ctrl_reg[`ADCR_BIT_GO];
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("go kept while off");
  property p_go_kept;
    @(posedge clk) disable iff (!rst_n)
      state_reg == adcr_pkg::ADCR_CONVERT && goWrite && hwdata[`ADCR_BIT_ON]
        |=> ctrl_reg[`ADCR_BIT_GO];
  endproperty
  a_go_kept: assert property (p_go_kept) else $error("go lost on write");
  property p_sel_follow;
    @(posedge clk) disable iff (!rst_n)
      ##1 inputSelect == $past(ctrl_reg[`ADCR_SEL_HI:`ADCR_SEL_LO]);
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("channel mismatch");
  property p_strobe_follow;
    @(posedge clk) disable iff (!rst_n)
      ##1 sampleStrobe == $past(state_reg == adcr_pkg::ADCR_CONVERT);
  endproperty
  a_strobe_follow: assert property (p_strobe_follow) else $error("strobe mismatch");
  property p_left_top;
    @(posedge clk) disable iff (!rst_n)
      !ctrl_reg[`ADCR_BIT_JUSTIFY] |-> resLow[7:6] == result_reg[1:0];
  endproperty
  a_left_top: assert property (p_left_top) else $error("left low bits");
  property p_right_low;
    @(posedge clk) disable iff (!rst_n)
      ctrl_reg[`ADCR_BIT_JUSTIFY] |-> resHigh[1:0] == result_reg[9:8];
  endproperty
  a_right_low: assert property (p_right_low) else $error("right high bits");
  property p_result_hold;
    @(posedge clk) disable iff (!rst_n)
      state_reg != adcr_pkg::ADCR_STORE |-> $stable(result_reg);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");
  property p_store_agree;
    @(posedge clk) disable iff (!rst_n)
      state_reg == adcr_pkg::ADCR_STORE |-> $past(dataSync_reg[1] == dataSync_reg[2]);
  endproperty
  a_store_agree: assert property (p_store_agree) else $error("unsettled sample");
  property p_rd_upper;
    @(posedge clk) disable iff (!rst_n)
      hrdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");

  // Cycles spent in the convert state, so the length can be bounded below
  logic [13:0] runCnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runCnt_reg <= 14'h0000;
    end else if (state_reg != adcr_pkg::ADCR_CONVERT) begin
      runCnt_reg <= 14'h0000;
    end else if (runCnt_reg != 14'h3fff) begin
      runCnt_reg <= runCnt_reg + 14'h0001;
    end
  end
  property p_full_length;
    @(posedge clk) disable iff (!rst_n)
      state_reg == adcr_pkg::ADCR_STORE |-> runCnt_reg >= 14'(CONV_CYC);
  endproperty
  a_full_length: assert property (p_full_length) else $error("conversion too short");
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "adcr_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] sampleData = 10'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic converterEnable;
  logic externalRefSelect;
  logic [2:0] inputSelect;
  logic sampleStrobe;
  logic [31:0] rd;
  int nErrors = 0;
  int cmpCount = 0;
  always #5 clk = ~clk;
  // Short conversion keeps polling loops brief
  adcr_control #(.CONV_CYC(4)) i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sampleData(sampleData),
    .converterEnable(converterEnable), .externalRefSelect(externalRefSelect),
    .inputSelect(inputSelect), .sampleStrobe(sampleStrobe));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `ADCR_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= `ADCR_HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    bus(1'b0, `ADCR_ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    bus(1'b0, `ADCR_ADDR_DATA, 32'h0);
    chk("unmapped read", rd, 32'h0);
  endtask
  task automatic t_fields();
    logic [31:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {24'h0, 1'b0, c[0], 1'b1, c[2:0], 2'b01};
      bus(1'b1, `ADCR_ADDR_CTRL, v);
      settle();
      chk("channel", {29'h0, inputSelect}, {29'h0, c[2:0]});
      chk("ref select", {31'h0, externalRefSelect}, {31'h0, c[0]});
      chk("enable on", {31'h0, converterEnable}, 32'h1);
      bus(1'b0, `ADCR_ADDR_CTRL, 32'h0);
      chk("ctrl readback", rd, v & 32'h000000df);
    end
    bus(1'b1, `ADCR_ADDR_CTRL, 32'h0);
    settle();
    chk("enable off", {31'h0, converterEnable}, 32'h0);
  endtask
  task automatic t_go_off();
    // Go without the converter on must stay idle
    bus(1'b1, `ADCR_ADDR_CTRL, 32'h2);
    settle();
    chk("strobe off", {31'h0, sampleStrobe}, 32'h0);
    bus(1'b0, `ADCR_ADDR_CTRL, 32'h0);
    chk("go off", rd, 32'h0);
  endtask
  task automatic t_convert(input logic j, input logic [9:0] d);
    int n;
    sampleData <= d;
    repeat (5) @(posedge clk);
    bus(1'b1, `ADCR_ADDR_CTRL, {24'h0, j, 7'h03});
    settle();
    chk("strobe", {31'h0, sampleStrobe}, 32'h1);
    bus(1'b0, `ADCR_ADDR_CTRL, 32'h0);
    chk("go busy", {31'h0, rd[1]}, 32'h1);
    n = 0;
    do begin
      bus(1'b0, `ADCR_ADDR_CTRL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 40);
    chk("go done", {31'h0, rd[1]}, 32'h0);
    bus(1'b0, `ADCR_ADDR_RESH, 32'h0);
    chk("high", rd, j ? {30'h0, d[9:8]} : {24'h0, d[9:2]});
    bus(1'b0, `ADCR_ADDR_RESL, 32'h0);
    chk("low", rd, j ? {24'h0, d[7:0]} : {24'h0, d[1:0], 6'h0});
  endtask
  task automatic t_abort();
    // New sample present, so a conversion that is not cut short would overwrite the result
    sampleData <= 10'h0f0;
    repeat (5) @(posedge clk);
    bus(1'b1, `ADCR_ADDR_CTRL, 32'h3);
    bus(1'b1, `ADCR_ADDR_CTRL, 32'h0);
    repeat (2) settle();
    chk("abort strobe", {31'h0, sampleStrobe}, 32'h0);
    bus(1'b0, `ADCR_ADDR_CTRL, 32'h0);
    chk("abort go", rd, 32'h0);
    bus(1'b0, `ADCR_ADDR_RESH, 32'h0);
    chk("abort keeps result", rd, 32'h00000052);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200000;
    nErrors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_go_off();
    // Full-scale code in the left layout, mixed codes in both layouts
    t_convert(1'b0, 10'h2b5);
    t_convert(1'b1, 10'h2b5);
    t_convert(1'b0, 10'h3ff);
    t_convert(1'b1, 10'h14a);
    t_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire
